// >>> logic/iox_top.sv
// two-port expander register and interrupt unit
`timescale 1ns/10ps
module iox_top
    import iox_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [PORT_W-1:0] first_port_pins_in,
    input wire logic [PORT_W-1:0] second_port_pins_in,
    input wire logic [PORT_W-1:0] pin_direction_a_in,
    input wire logic [PORT_W-1:0] pin_direction_b_in,
    input wire logic [PORT_W-1:0] change_irq_enable_a_in,
    input wire logic [PORT_W-1:0] change_irq_enable_b_in,
    input wire logic [PORT_W-1:0] compare_select_a_in,
    input wire logic [PORT_W-1:0] compare_select_b_in,
    input wire logic [PORT_W-1:0] default_compare_value_a_in,
    input wire logic [PORT_W-1:0] default_compare_value_b_in,
    input wire logic mirror_in,
    input wire logic irq_open_drain_in,
    input wire logic irq_polarity_in,
    input wire logic reg_port_sel_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [PORT_W-1:0] reg_wr_data_in,
    input wire logic reg_rd_done_in,
    output logic [PORT_W-1:0] reg_rd_data_out,
    output logic [PORT_W-1:0] first_port_latch_out,
    output logic [PORT_W-1:0] second_port_latch_out,
    output logic [PORT_W-1:0] first_port_pullup_out,
    output logic [PORT_W-1:0] second_port_pullup_out,
    output logic irq_out_first_out,
    output logic irq_out_first_oe_out,
    output logic irq_out_second_out,
    output logic irq_out_second_oe_out
);
    logic [PORT_W-1:0] pa_meta_q;
    logic [PORT_W-1:0] pa_sync_q;
    logic [PORT_W-1:0] pb_meta_q;
    logic [PORT_W-1:0] pb_sync_q;
    logic [PORT_W-1:0] rd_a;
    logic [PORT_W-1:0] rd_b;
    logic [PORT_W-1:0] latch_a;
    logic [PORT_W-1:0] latch_b;
    logic [PORT_W-1:0] pu_a;
    logic [PORT_W-1:0] pu_b;
    logic irq_a;
    logic irq_b;
    logic wr_a;
    logic wr_b;
    logic done_a;
    logic done_b;
    logic act_first;
    logic act_second;
    logic lvl_first;
    logic lvl_second;
    logic oe_first;
    logic oe_second;
    logic [PORT_W-1:0] rd_sel;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pa_meta_q <= RST_BYTE;
            pa_sync_q <= RST_BYTE;
            pb_meta_q <= RST_BYTE;
            pb_sync_q <= RST_BYTE;
        end else begin
            pa_meta_q <= first_port_pins_in;
            pa_sync_q <= pa_meta_q;
            pb_meta_q <= second_port_pins_in;
            pb_sync_q <= pb_meta_q;
        end
    end

    // ****************************************
    // port select
    // ****************************************
    assign wr_a = reg_wr_en_in && reg_port_sel_in == PORT_A;
    assign wr_b = reg_wr_en_in && reg_port_sel_in == PORT_B;
    assign done_a = reg_rd_done_in && reg_port_sel_in == PORT_A;
    assign done_b = reg_rd_done_in && reg_port_sel_in == PORT_B;

    // ****************************************
    // ports
    // ****************************************
    iox_port u_port_a (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_sync_in(pa_sync_q),
        .pin_direction_in(pin_direction_a_in),
        .change_irq_enable_in(change_irq_enable_a_in),
        .compare_select_in(compare_select_a_in),
        .default_compare_value_in(default_compare_value_a_in),
        .wr_en_in(wr_a),
        .wr_addr_in(reg_addr_in),
        .wr_data_in(reg_wr_data_in),
        .rd_addr_in(reg_addr_in),
        .rd_done_in(done_a),
        .rd_data_out(rd_a),
        .irq_out(irq_a),
        .latch_bits_out(latch_a),
        .pullup_active_out(pu_a)
    );

    iox_port u_port_b (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_sync_in(pb_sync_q),
        .pin_direction_in(pin_direction_b_in),
        .change_irq_enable_in(change_irq_enable_b_in),
        .compare_select_in(compare_select_b_in),
        .default_compare_value_in(default_compare_value_b_in),
        .wr_en_in(wr_b),
        .wr_addr_in(reg_addr_in),
        .wr_data_in(reg_wr_data_in),
        .rd_addr_in(reg_addr_in),
        .rd_done_in(done_b),
        .rd_data_out(rd_b),
        .irq_out(irq_b),
        .latch_bits_out(latch_b),
        .pullup_active_out(pu_b)
    );

    // ****************************************
    // interrupt routing and pin driver
    // ****************************************
    assign act_first = mirror_in ? (irq_a | irq_b) : irq_a;
    assign act_second = mirror_in ? (irq_a | irq_b) : irq_b;
    // open-drain: pull low only while active
    assign lvl_first = irq_open_drain_in ? 1'b0
        : (irq_polarity_in ? act_first : !act_first);
    assign lvl_second = irq_open_drain_in ? 1'b0
        : (irq_polarity_in ? act_second : !act_second);
    assign oe_first = irq_open_drain_in ? act_first : 1'b1;
    assign oe_second = irq_open_drain_in ? act_second : 1'b1;
    assign rd_sel = (reg_port_sel_in == PORT_A) ? rd_a : rd_b;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rd_data_out <= RST_BYTE;
            first_port_latch_out <= RST_BYTE;
            second_port_latch_out <= RST_BYTE;
            first_port_pullup_out <= RST_BYTE;
            second_port_pullup_out <= RST_BYTE;
            irq_out_first_out <= 1'b1;
            irq_out_first_oe_out <= 1'b1;
            irq_out_second_out <= 1'b1;
            irq_out_second_oe_out <= 1'b1;
        end else begin
            reg_rd_data_out <= rd_sel;
            first_port_latch_out <= latch_a;
            second_port_latch_out <= latch_b;
            first_port_pullup_out <= pu_a;
            second_port_pullup_out <= pu_b;
            irq_out_first_out <= lvl_first;
            irq_out_first_oe_out <= oe_first;
            irq_out_second_out <= lvl_second;
            irq_out_second_oe_out <= oe_second;
        end
    end
endmodule : iox_top

// >>> pkg/iox_pkg.sv
// constants and register map for the expander port and interrupt unit
package iox_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_PULLUP_ENABLE = 5'h06;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_FLAGS = 5'h07;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CAPTURE = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_PORT_VALUE = 5'h09;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 5'h0a;
    localparam logic [PORT_W-1:0] RST_BYTE = 8'h00;
    localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;
    // host register bus: selects port A (0) or port B (1)
    localparam logic PORT_A = 1'b0;
    localparam logic PORT_B = 1'b1;
endpackage : iox_pkg

// >>> logic/iox_port.sv
// one 8-bit port: registers, compare and capture logic
`timescale 1ns/10ps
module iox_port
    import iox_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [PORT_W-1:0] pins_sync_in,
    input wire logic [PORT_W-1:0] pin_direction_in,
    input wire logic [PORT_W-1:0] change_irq_enable_in,
    input wire logic [PORT_W-1:0] compare_select_in,
    input wire logic [PORT_W-1:0] default_compare_value_in,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [PORT_W-1:0] wr_data_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    input wire logic rd_done_in,
    output logic [PORT_W-1:0] rd_data_out,
    output logic irq_out,
    output logic [PORT_W-1:0] latch_bits_out,
    output logic [PORT_W-1:0] pullup_active_out
);
    logic [PORT_W-1:0] pullup_bits_q;
    logic [PORT_W-1:0] latch_bits_q;
    logic [PORT_W-1:0] flags_q;
    logic [PORT_W-1:0] capture_bits_q;
    logic [PORT_W-1:0] prev_q;
    logic irq_q;
    logic [PORT_W-1:0] ref_val;
    logic [PORT_W-1:0] mismatch;
    logic [PORT_W-1:0] cond;
    logic clear_evt;
    logic fire;
    logic wr_pullup;
    logic wr_latch;

    // ****************************************
    // compare and event detection
    // ****************************************
    assign ref_val = (compare_select_in & default_compare_value_in)
        | (~compare_select_in & prev_q);
    assign mismatch = pins_sync_in ^ ref_val;
    assign cond = mismatch & change_irq_enable_in
        & pin_direction_in;
    assign clear_evt = rd_done_in &&
        (rd_addr_in == OFS_PORT_VALUE ||
         rd_addr_in == OFS_INTERRUPT_CAPTURE);
    // a clear with a condition still present re-fires at once
    assign fire = (|cond) && (!irq_q || clear_evt);
    assign wr_pullup = wr_en_in && wr_addr_in == OFS_PULLUP_ENABLE;
    assign wr_latch = wr_en_in && (wr_addr_in == OFS_OUTPUT_LATCH ||
        wr_addr_in == OFS_PORT_VALUE);

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pullup_bits_q <= RST_BYTE;
            latch_bits_q <= RST_BYTE;
        end else begin
            if (wr_pullup) begin
                pullup_bits_q <= wr_data_in;
            end
            if (wr_latch) begin
                latch_bits_q <= wr_data_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_q <= 1'b0;
            flags_q <= RST_BYTE;
            capture_bits_q <= RST_BYTE;
            prev_q <= RST_BYTE;
        end else if (fire) begin
            irq_q <= 1'b1;
            flags_q <= cond;
            capture_bits_q <= pins_sync_in;
            prev_q <= pins_sync_in;
        end else if (clear_evt) begin
            irq_q <= 1'b0;
            flags_q <= RST_BYTE;
            prev_q <= pins_sync_in;
        end else if (!irq_q) begin
            prev_q <= pins_sync_in;
        end
    end

    // ****************************************
    // read mux and outputs
    // ****************************************
    always_comb begin
        case (rd_addr_in)
            OFS_PULLUP_ENABLE: rd_data_out = pullup_bits_q;
            OFS_INTERRUPT_FLAGS: rd_data_out = flags_q;
            OFS_INTERRUPT_CAPTURE: rd_data_out = capture_bits_q;
            OFS_PORT_VALUE: rd_data_out = pins_sync_in;
            OFS_OUTPUT_LATCH: rd_data_out = latch_bits_q;
            default: rd_data_out = RST_BYTE;
        endcase
    end

    assign irq_out = irq_q;
    assign latch_bits_out = latch_bits_q;
    assign pullup_active_out = pullup_bits_q & pin_direction_in;
endmodule : iox_port

// >>> sim/iox_monitor.sv
// port assertions for the expander unit
`timescale 1ns/10ps
module iox_monitor
    import iox_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [PORT_W-1:0] pin_direction_a_in,
    input wire logic mirror_in,
    input wire logic irq_open_drain_in,
    input wire logic reg_port_sel_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [PORT_W-1:0] reg_wr_data_in,
    input wire logic [PORT_W-1:0] reg_rd_data_out,
    input wire logic [PORT_W-1:0] first_port_latch_out,
    input wire logic [PORT_W-1:0] first_port_pullup_out,
    input wire logic irq_out_first_out,
    input wire logic irq_out_first_oe_out,
    input wire logic irq_out_second_out,
    input wire logic irq_out_second_oe_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wire wr_a = reg_wr_en_in && !reg_port_sel_in
        && reg_addr_in inside {5'h09, 5'h0a};
    sequence s_wr_a;
        wr_a;
    endsequence
    // latch output lags the latch register by one flop
    AST_LATCH_WR: assert property (s_wr_a |-> ##2
        first_port_latch_out == $past(reg_wr_data_in, 2))
        else $error("latch missed a write");
    AST_LATCH_HOLD: assert property (!wr_a && !$past(wr_a) |=>
        $stable(first_port_latch_out))
        else $error("latch moved without a write");
    AST_RD_LATCH: assert property (
        !reg_port_sel_in && reg_addr_in == 5'h0a |=>
        reg_rd_data_out == first_port_latch_out)
        else $error("latch readback differs");
    AST_RD_UNMAPPED: assert property (
        !(reg_addr_in inside {[5'h06:5'h0a]}) |=> reg_rd_data_out == 8'h00)
        else $error("unmapped read not zero");
    AST_MIRROR: assert property (
        $past(rst_b_in) && $past(mirror_in) |->
        irq_out_first_out == irq_out_second_out
        && irq_out_first_oe_out == irq_out_second_oe_out)
        else $error("mirrored outputs differ");
    AST_OD_FIRST: assert property (
        $past(rst_b_in) && $past(irq_open_drain_in) |->
        !(irq_out_first_oe_out && irq_out_first_out))
        else $error("open drain drove high");
    AST_OD_SECOND: assert property (
        $past(rst_b_in) && $past(irq_open_drain_in) |->
        !(irq_out_second_oe_out && irq_out_second_out))
        else $error("open drain drove high");
    AST_PUSH_OE: assert property (
        $past(rst_b_in) && !$past(irq_open_drain_in) |->
        irq_out_first_oe_out && irq_out_second_oe_out)
        else $error("push-pull driver off");
    AST_PULLUP: assert property ($past(rst_b_in) |->
        (first_port_pullup_out & ~$past(pin_direction_a_in)) == 8'h00)
        else $error("pull-up on output pin");
endmodule : iox_monitor
bind iox_top iox_monitor u_mon (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .pin_direction_a_in(pin_direction_a_in), .mirror_in(mirror_in),
    .irq_open_drain_in(irq_open_drain_in),
    .reg_port_sel_in(reg_port_sel_in), .reg_addr_in(reg_addr_in),
    .reg_wr_en_in(reg_wr_en_in), .reg_wr_data_in(reg_wr_data_in),
    .reg_rd_data_out(reg_rd_data_out),
    .first_port_latch_out(first_port_latch_out),
    .first_port_pullup_out(first_port_pullup_out),
    .irq_out_first_out(irq_out_first_out),
    .irq_out_first_oe_out(irq_out_first_oe_out),
    .irq_out_second_out(irq_out_second_out),
    .irq_out_second_oe_out(irq_out_second_oe_out));

// >>> sim/iox_host_model.sv
// host side model driving the register access port
`timescale 1ns/10ps
module iox_host_model
    import iox_pkg::*;
(
    input wire logic clk_in,
    input wire logic [PORT_W-1:0] rd_data_in,
    output logic sel_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic wr_en_out,
    output logic [PORT_W-1:0] wr_data_out,
    output logic rd_done_out
);
    initial begin
        sel_out = 1'b0;
        addr_out = 5'h00;
        wr_en_out = 1'b0;
        wr_data_out = 8'h00;
        rd_done_out = 1'b0;
    end
    task automatic wr(input logic s, input logic [ADDR_W-1:0] a,
                      input logic [PORT_W-1:0] d);
        @(posedge clk_in);
        sel_out <= s;
        addr_out <= a;
        wr_data_out <= d;
        wr_en_out <= 1'b1;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
    endtask : wr
    // clr drives rd_done_out for one cycle to mark the read complete
    task automatic rd(input logic s, input logic [ADDR_W-1:0] a,
                      input logic clr, output logic [PORT_W-1:0] d);
        @(posedge clk_in);
        sel_out <= s;
        addr_out <= a;
        @(posedge clk_in);
        rd_done_out <= clr;
        #1 d = rd_data_in;
        @(posedge clk_in);
        rd_done_out <= 1'b0;
    endtask : rd
endmodule : iox_host_model

// >>> sim/tb_top.sv
// testbench for the two-port expander unit
`timescale 1ns/10ps
module tb_top
    import iox_pkg::*;
;
    logic clk_in, rst_b_in, mir, od, pol, sel, wen, rdn, ia, iao, ib, ibo;
    logic [PORT_W-1:0] pa, pb, dira, dirb, ena, enb, csa, csb, dva, dvb;
    logic [PORT_W-1:0] rdat, la, lb, ua, ub, wdat, d;
    logic [ADDR_W-1:0] addr;
    int miscompares = 0;
    int n_compared = 0;
    iox_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .first_port_pins_in(pa), .second_port_pins_in(pb),
        .pin_direction_a_in(dira), .pin_direction_b_in(dirb),
        .change_irq_enable_a_in(ena), .change_irq_enable_b_in(enb),
        .compare_select_a_in(csa), .compare_select_b_in(csb),
        .default_compare_value_a_in(dva),
        .default_compare_value_b_in(dvb), .mirror_in(mir),
        .irq_open_drain_in(od), .irq_polarity_in(pol),
        .reg_port_sel_in(sel), .reg_addr_in(addr), .reg_wr_en_in(wen),
        .reg_wr_data_in(wdat), .reg_rd_done_in(rdn),
        .reg_rd_data_out(rdat), .first_port_latch_out(la),
        .second_port_latch_out(lb), .first_port_pullup_out(ua),
        .second_port_pullup_out(ub), .irq_out_first_out(ia),
        .irq_out_first_oe_out(iao), .irq_out_second_out(ib),
        .irq_out_second_oe_out(ibo));
    iox_host_model host (.clk_in(clk_in), .rd_data_in(rdat),
        .sel_out(sel), .addr_out(addr), .wr_en_out(wen),
        .wr_data_out(wdat), .rd_done_out(rdn));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic chk(input logic [PORT_W-1:0] g, input logic [PORT_W-1:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic s, input logic [ADDR_W-1:0] a,
                       input logic c, input logic [PORT_W-1:0] e);
        host.rd(s, a, c, d);
        chk(d, e);
    endtask : rdc
    // bits: first level, second level, first enable, second enable
    task automatic irq(input logic [3:0] e, input logic [3:0] m);
        repeat (5) @(posedge clk_in);
        #1 chk({4'h0, {ia, ib, iao, ibo} & m}, {4'h0, e});
        @(posedge clk_in);
    endtask : irq
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        report_and_stop();
    end
    initial begin
        {rst_b_in, mir, od, pol, pa, pb, csa, dva, dvb} = '0;
        {dira, dirb, ena, enb, csb} = {8'h0f, 8'hff, 8'hff, 8'h01, 8'h01};
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            rdc(i[0], 5'h06 + 5'(i % 5), 1'b0, 8'h00);
        end
        $display("reset values done");
        host.wr(1'b0, 5'h06, 8'h5a);
        host.wr(1'b1, 5'h06, 8'ha5);
        rdc(1'b0, 5'h06, 1'b0, 8'h5a);
        chk(ua, 8'h0a);
        chk(ub, 8'ha5);
        host.wr(1'b0, 5'h07, 8'hff);
        rdc(1'b0, 5'h07, 1'b0, 8'h00);
        host.wr(1'b0, 5'h09, 8'h3c);
        @(posedge clk_in);
        #1 chk(la, 8'h3c);
        host.wr(1'b0, 5'h0a, 8'hc3);
        rdc(1'b0, 5'h0a, 1'b0, 8'hc3);
        $display("register access done");
        pa <= 8'h06;
        irq(4'b0111, 4'hf);
        rdc(1'b0, 5'h07, 1'b0, 8'h06);
        pa <= 8'h07;
        rdc(1'b0, 5'h08, 1'b0, 8'h06);
        host.wr(1'b0, 5'h08, 8'h00);
        host.wr(1'b0, 5'h09, 8'h00);
        irq(4'b0111, 4'hf);
        rdc(1'b0, 5'h09, 1'b1, 8'h07);
        irq(4'b0111, 4'hf);
        rdc(1'b0, 5'h07, 1'b0, 8'h01);
        rdc(1'b0, 5'h08, 1'b1, 8'h07);
        irq(4'b1111, 4'hf);
        pa <= 8'h87;
        irq(4'b1111, 4'hf);
        $display("pin change done");
        pb <= 8'h01;
        irq(4'b1011, 4'hf);
        rdc(1'b1, 5'h08, 1'b1, 8'h01);
        irq(4'b1011, 4'hf);
        mir <= 1'b1;
        pa <= 8'h85;
        irq(4'b0011, 4'hf);
        rdc(1'b0, 5'h09, 1'b1, 8'h85);
        irq(4'b0011, 4'hf);
        pb <= 8'h00;
        repeat (2) @(posedge clk_in);
        rdc(1'b1, 5'h09, 1'b1, 8'h00);
        irq(4'b1111, 4'hf);
        $display("default and mirror done");
        mir <= 1'b0;
        pol <= 1'b1;
        irq(4'b0011, 4'hf);
        od <= 1'b1;
        pa <= 8'h84;
        irq(4'b0010, 4'b1011);
        rdc(1'b0, 5'h08, 1'b1, 8'h84);
        irq(4'b0000, 4'b0011);
        $display("output modes done");
        report_and_stop();
    end
endmodule : tb_top
